// file: src/lock_seq_ctrl.sv
// locked read-modify-write bus sequence controller
`timescale 1ns/1ps
module lock_seq_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // core request
   input wire logic req_valid_i,
   input wire lock_seq_pkg::kind_e req_kind_i,
   input wire logic req_line_m_i,
   input wire logic req_misaligned_i,
   input wire logic pt_update_i,
   output logic req_ready_o,
   output logic seq_done_o,
   output logic line_inval_o,
   // cache snoop port
   output logic snoop_look_o,
   input wire logic snoop_hit_m_i,
   // bus outputs
   output logic addr_strobe_n_o,
   output lock_seq_pkg::op_e cycle_op_o,
   output logic atomic_lock_n_o,
   output logic atomic_lock_oe_o,
   output logic split_cycle_flag_o,
   output logic yield_ack_o,
   // bus inputs
   input wire logic burst_ready_n_i,
   input wire logic backoff_n_i,
   input wire logic addr_freeze_req_i,
   input wire logic bus_yield_req_i,
   input wire logic snoop_addr_strobe_n_i
);
   import lock_seq_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_BACKOFF, S_GAP, S_YIELD} state_e;
   state_e state_reg, state_next;
   logic [2:0] idx_reg, idx_next;
   logic [1:0] beat_reg, beat_next;
   logic ins_wb_reg, ins_wb_next;
   logic snp_pend_reg, snp_pend_next;
   op_e ops_reg [MAX_OPS];
   logic [2:0] n_ops_reg, first_lock_reg;
   logic split_ok_reg, inval_ok_reg;
   kind_e kind_reg;
   logic snoop_addr_strobe_n_d_reg;
   logic done_next;
   logic [4:0] pin_raw, pin_s;
   seq_plan_if plan ();

   // plan follows the request port; only latched when taken
   assign plan.kind = req_kind_i;
   assign plan.line_m = req_line_m_i;
   assign plan.mis = req_misaligned_i;
   seq_planner u_plan (
      .p(plan.planner)
   );

   // all bus pins are asynchronous to the core clock
   assign pin_raw = {snoop_addr_strobe_n_i, bus_yield_req_i, addr_freeze_req_i, backoff_n_i, burst_ready_n_i};
   pin_sync #(.W(5), .INIT(PIN_IDLE)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );
   wire burst_ready_n = !pin_s[PIN_BURST_READY_N];
   wire bo = !pin_s[PIN_BACKOFF_N];
   wire frz = pin_s[PIN_FRZ];
   wire yreq = pin_s[PIN_YREQ];
   wire snoop_addr_strobe_n = !pin_s[PIN_SNOOP_ADDR_STROBE_N];

   function automatic logic is_locked_op(input op_e op);
      is_locked_op = (op == OP_LRD) || (op == OP_LWR);
   endfunction

   // decode of the current step
   wire accept = req_ready_o && req_valid_i;
   wire op_e cur_op = ins_wb_reg ? OP_WB : ops_reg[idx_reg];
   wire last_beat = (cur_op != OP_WB) || (beat_reg == WB_LAST_BEAT);
   wire last_step = ((idx_reg + 3'h1) == n_ops_reg);
   wire pt_stop = (cur_op == OP_RD) && !pt_update_i;
   wire in_lock_reg = (idx_reg >= first_lock_reg);
   wire [2:0] idx_inc = idx_reg + 3'h1;
   wire wr_follows = (cur_op == OP_LRD) && (ops_reg[idx_inc] == OP_LWR);

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      beat_next = beat_reg;
      ins_wb_next = ins_wb_reg;
      done_next = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (accept) begin
               state_next = S_ISSUE;
               idx_next = 3'h0;
               beat_next = 2'h0;
               ins_wb_next = 1'b0;
            end else if (yreq) begin
               state_next = S_YIELD;
            end
         end
         S_ISSUE: begin
            state_next = bo ? S_BACKOFF : S_WAIT;
         end
         S_WAIT: begin
            if (bo) begin
               state_next = S_BACKOFF;
            end else if (burst_ready_n && !last_beat) begin
               beat_next = beat_reg + 2'h1;
            end else if (burst_ready_n) begin
               beat_next = 2'h0;
               if (ins_wb_reg) begin
                  ins_wb_next = 1'b0;
                  state_next = S_ISSUE;
               end else if (last_step || pt_stop) begin
                  state_next = in_lock_reg ? S_GAP : S_IDLE;
                  done_next = 1'b1;
               end else begin
                  idx_next = idx_inc;
                  state_next = S_ISSUE;
                  ins_wb_next = snp_pend_reg && in_lock_reg && wr_follows;
               end
            end
         end
         S_BACKOFF: begin
            if (!bo) begin
               state_next = S_ISSUE;
               beat_next = 2'h0;
               if (snp_pend_reg) begin
                  ins_wb_next = 1'b1;
               end
               if (!ins_wb_reg && cur_op == OP_LRD) begin
                  idx_next = first_lock_reg;
               end
            end
         end
         S_GAP: begin
            state_next = S_IDLE;
         end
         S_YIELD: begin
            if (!yreq) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // decode of the step being entered
   wire [2:0] fl_sel = accept ? plan.first_lock : first_lock_reg;
   wire split_sel = accept ? plan.split : split_ok_reg;
   wire inval_sel = accept ? plan.inval : inval_ok_reg;
   wire op_e step_op = accept ? plan.ops[0] : ops_reg[idx_next];
   wire op_e op_next = ins_wb_next ? OP_WB : step_op;
   wire on_bus_next = (state_next == S_ISSUE) || (state_next == S_WAIT);
   wire lock_region = (idx_next >= fl_sel);
   // frz is not looked at here, so a freeze never drops the lock
   wire lock_act_next = on_bus_next && lock_region && (ins_wb_next || is_locked_op(op_next));
   wire entering = accept || (state_reg == S_WAIT && state_next == S_ISSUE && idx_next != idx_reg);
   wire inval_next = entering && !ins_wb_next && (idx_next == fl_sel) && inval_sel;
   wire snoop_window = frz || bo || yield_ack_o;
   wire snoop_look_next = snoop_addr_strobe_n && !snoop_addr_strobe_n_d_reg && snoop_window;
   wire wb_start = (state_next == S_ISSUE) && ins_wb_next && !ins_wb_reg;
   // a hit landing with the clear still counts
   assign snp_pend_next = snoop_hit_m_i || (snp_pend_reg && !wb_start && state_reg != S_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         idx_reg <= 3'h0;
         beat_reg <= 2'h0;
         ins_wb_reg <= 1'b0;
         snp_pend_reg <= 1'b0;
         snoop_addr_strobe_n_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         beat_reg <= beat_next;
         ins_wb_reg <= ins_wb_next;
         snp_pend_reg <= snp_pend_next;
         snoop_addr_strobe_n_d_reg <= snoop_addr_strobe_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < MAX_OPS; i++) begin
            ops_reg[i] <= OP_NONE;
         end
         n_ops_reg <= 3'h0;
         first_lock_reg <= 3'h0;
         split_ok_reg <= 1'b0;
         inval_ok_reg <= 1'b0;
         kind_reg <= K_PROG;
      end else if (accept) begin
         ops_reg <= plan.ops;
         n_ops_reg <= plan.n_ops;
         first_lock_reg <= plan.first_lock;
         split_ok_reg <= plan.split;
         inval_ok_reg <= plan.inval;
         kind_reg <= req_kind_i;
      end
   end

   // every pin comes from a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_ready_o <= 1'b0;
         seq_done_o <= 1'b0;
         line_inval_o <= 1'b0;
         snoop_look_o <= 1'b0;
         addr_strobe_n_o <= 1'b1;
         cycle_op_o <= OP_NONE;
         atomic_lock_n_o <= 1'b1;
         atomic_lock_oe_o <= 1'b1;
         split_cycle_flag_o <= 1'b0;
         yield_ack_o <= 1'b0;
      end else begin
         req_ready_o <= (state_next == S_IDLE) && !accept;
         seq_done_o <= done_next;
         line_inval_o <= inval_next;
         snoop_look_o <= snoop_look_next;
         addr_strobe_n_o <= !(state_next == S_ISSUE);
         cycle_op_o <= on_bus_next ? op_next : OP_NONE;
         atomic_lock_n_o <= !lock_act_next;
         atomic_lock_oe_o <= !(state_next == S_BACKOFF || state_next == S_YIELD);
         split_cycle_flag_o <= lock_act_next && split_sel;
         yield_ack_o <= (state_next == S_YIELD);
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [2:0] lock_depth = idx_reg - first_lock_reg;
   lock_with_strobe_a: assert property ($fell(atomic_lock_n_o) |-> !addr_strobe_n_o)
      else $error("lock asserted without address strobe");
   lock_idle_gap_a: assert property ($rose(atomic_lock_n_o) && !addr_strobe_n_o |-> 0)
      else $error("lock released in a strobe clock");
   lock_gap_hold_a: assert property ($rose(atomic_lock_n_o) && state_reg == S_GAP |=> atomic_lock_n_o)
      else $error("no idle clock between locked operations");
   split_needs_lock_a: assert property (split_cycle_flag_o |-> !atomic_lock_n_o && kind_reg != K_PT)
      else $error("split flag outside misaligned lock");
   yield_not_locked_a: assert property (yield_ack_o |-> !atomic_lock_oe_o && atomic_lock_n_o)
      else $error("yield granted while lock driven");
   backoff_float_a: assert property (state_reg == S_BACKOFF |-> !atomic_lock_oe_o && addr_strobe_n_o)
      else $error("lock driven during backoff");
   lock_count_a: assert property (!addr_strobe_n_o && !atomic_lock_n_o && !ins_wb_reg |-> lock_depth < MAX_LOCKED)
      else $error("more than four cycles locked");
   snoop_window_a: assert property (snoop_look_o |-> $past(snoop_window))
      else $error("snoop taken outside its window");
   freeze_keeps_lock_a: assert property (frz && state_reg == S_WAIT && !atomic_lock_n_o && !burst_ready_n && !bo
      |=> !atomic_lock_n_o)
      else $error("freeze dropped the lock");
   inval_before_lock_a: assert property (line_inval_o |-> !addr_strobe_n_o && (atomic_lock_n_o || !inval_ok_reg)
      || !atomic_lock_n_o)
      else $error("invalidate out of place");
   misaligned_lock_c: cover property (split_cycle_flag_o ##[1:200] seq_done_o);
   backoff_restart_c: cover property (state_reg == S_BACKOFF ##[1:20] !addr_strobe_n_o && !atomic_lock_n_o);
   inserted_wb_c: cover property (ins_wb_reg && !atomic_lock_n_o);
   yield_after_lock_c: cover property (seq_done_o ##[1:4] yield_ack_o);
endmodule // lock_seq_ctrl

// file: src/lock_seq_pkg.sv
// constants and types for the locked bus sequence control
// Functional notes
// - locked op: reads first, then writes
// - lock for prefix, exchange, descriptors, tables, acknowledge
// - modified line: writeback, invalidate, then locked read
// - misaligned: two writebacks, four locked, split flagged
// - aligned: writeback, locked read, locked write
// - clean line: no writeback, line left invalid
// - table miss: unlocked read before optional locked update
// - modified table line: read, writeback, locked pair
// - clean table line: locked read then locked write
// - table updates never raise split flag
// - address freeze keeps lock asserted
// - lock floats in yield; yield waits sequence end
// - backoff floats lock; read restarts, write redriven
// - snoop strobe ignored outside freeze, backoff, yield
// - backoff snoop writeback runs first, lock asserted
// - freeze snoop writeback between read and write
// - no internal writebacks inside locked sequence
// - lock from first strobe to last ready
// - idle clock between consecutive locked operations
// - at most four own cycles locked
// - strobe clock is first clock of cycle
package lock_seq_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_RD, OP_WB, OP_LRD, OP_LWR} op_e;
   typedef enum logic [2:0] {K_PROG, K_DESC, K_XCHG, K_PT, K_INTA} kind_e;
   localparam int MAX_OPS = 6;
   localparam int SYNC_STAGES = 2;
   localparam logic [2:0] MAX_LOCKED = 3'h4;
   localparam logic [1:0] WB_LAST_BEAT = 2'h3;
   localparam logic [4:0] PIN_IDLE = 5'h13;
   localparam int PIN_BURST_READY_N = 0;
   localparam int PIN_BACKOFF_N = 1;
   localparam int PIN_FRZ = 2;
   localparam int PIN_YREQ = 3;
   localparam int PIN_SNOOP_ADDR_STROBE_N = 4;
endpackage

// file: src/seq_plan_if.sv
// plan of bus cycles passed from planner to controller
`timescale 1ns/1ps
interface seq_plan_if;
   import lock_seq_pkg::*;
   kind_e kind;
   logic line_m;
   logic mis;
   op_e ops [MAX_OPS];
   logic [2:0] n_ops;
   logic [2:0] first_lock;
   logic split;
   logic inval;
   modport planner (input kind, line_m, mis, output ops, n_ops, first_lock, split, inval);
   modport ctrl (output kind, line_m, mis, input ops, n_ops, first_lock, split, inval);
endinterface

// file: src/pin_sync.sv
// two-stage synchroniser for bus pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pins in and synced out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import lock_seq_pkg::*;
   logic [W-1:0] meta_reg;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_reg[g] <= INIT[g];
               q_o[g] <= INIT[g];
            end else begin
               meta_reg[g] <= d_i[g];
               q_o[g] <= meta_reg[g];
            end
         end
      end
   endgenerate
endmodule // pin_sync

// file: src/seq_planner.sv
// decides the bus cycle list for one locked request
`timescale 1ns/1ps
module seq_planner (
   seq_plan_if.planner p
);
   import lock_seq_pkg::*;
   wire is_pt = (p.kind == K_PT);
   wire is_inta = (p.kind == K_INTA);
   wire mis_ok = p.mis && !is_pt && !is_inta;
   always_comb begin
      for (int i = 0; i < MAX_OPS; i++) begin
         p.ops[i] = OP_NONE;
      end
      p.n_ops = 3'h2;
      p.first_lock = 3'h0;
      if (is_inta) begin
         p.ops[0] = OP_LRD;
         p.ops[1] = OP_LRD;
      end else if (is_pt && p.line_m) begin
         p.ops[0] = OP_RD;
         p.ops[1] = OP_WB;
         p.ops[2] = OP_LRD;
         p.ops[3] = OP_LWR;
         p.n_ops = 3'h4;
         p.first_lock = 3'h2;
      end else if (is_pt) begin
         p.ops[0] = OP_LRD;
         p.ops[1] = OP_LWR;
      end else if (mis_ok && p.line_m) begin
         p.ops[0] = OP_WB;
         p.ops[1] = OP_WB;
         p.ops[2] = OP_LRD;
         p.ops[3] = OP_LRD;
         p.ops[4] = OP_LWR;
         p.ops[5] = OP_LWR;
         p.n_ops = 3'h6;
         p.first_lock = 3'h2;
      end else if (mis_ok) begin
         p.ops[0] = OP_LRD;
         p.ops[1] = OP_LRD;
         p.ops[2] = OP_LWR;
         p.ops[3] = OP_LWR;
         p.n_ops = 3'h4;
      end else if (p.line_m) begin
         p.ops[0] = OP_WB;
         p.ops[1] = OP_LRD;
         p.ops[2] = OP_LWR;
         p.n_ops = 3'h3;
         p.first_lock = 3'h1;
      end else begin
         p.ops[0] = OP_LRD;
         p.ops[1] = OP_LWR;
      end
   end
   assign p.split = mis_ok;
   assign p.inval = !is_inta;
endmodule // seq_planner

// file: verif/bus_responder.sv
// system bus responder returning ready beats for each strobed cycle
`timescale 1ns/1ps
module bus_responder (
   // clock
   input wire logic clk_i,
   // cycle from the controller; backoff and delay from the bench
   input wire logic strobe_n_i,
   input wire lock_seq_pkg::op_e op_i,
   input wire logic backoff_n_i,
   input wire logic [3:0] delay_i,
   // answer
   output logic burst_ready_n_o
);
   import lock_seq_pkg::*;
   int beats = 0;
   int wait_cnt = 0;
   initial burst_ready_n_o = 1'b1;
   always @(posedge clk_i) begin
      burst_ready_n_o <= 1'b1; // pulled up when not answering
      if (!backoff_n_i) begin
         beats <= 0;
      end else if (!strobe_n_i) begin
         beats <= (op_i == OP_WB) ? 4 : 1;
         wait_cnt <= delay_i;
      end else if (beats > 0 && wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (beats > 0) begin
         burst_ready_n_o <= 1'b0;
         beats <= beats - 1;
      end
   end
endmodule // bus_responder

// file: verif/lock_seq_ctrl_tb.sv
// self-checking bench for the locked sequence controller
`timescale 1ns/1ps
module lock_seq_ctrl_tb;
   import lock_seq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   kind_e req_kind_i = K_PROG;
   logic req_line_m_i = 1'b0;
   logic req_misaligned_i = 1'b0;
   logic pt_update_i = 1'b1;
   logic snoop_hit_m_i = 1'b0;
   logic hit_en = 1'b0;
   logic backoff_n_i = 1'b1;
   logic addr_freeze_req_i = 1'b0;
   logic bus_yield_req_i = 1'b0;
   logic snoop_addr_strobe_n_i = 1'b1;
   logic [3:0] delay = 4'h2;
   logic burst_ready_n_i, req_ready_o, seq_done_o, line_inval_o, snoop_look_o, addr_strobe_n_o;
   logic atomic_lock_n_o, atomic_lock_oe_o, split_cycle_flag_o, yield_ack_o, lock_prev;
   op_e cycle_op_o;
   logic [4:0] seen_q[$];
   logic [4:0] exp_q[$];
   int mismatches = 0;
   int comparisons = 0;
   int inval_n = 0;
   always #10 clk_i = ~clk_i;
   lock_seq_ctrl lock_seq_ctrl_i (.clk_i, .rst_i, .req_valid_i, .req_kind_i, .req_line_m_i,
      .req_misaligned_i, .pt_update_i, .req_ready_o, .seq_done_o, .line_inval_o, .snoop_look_o,
      .snoop_hit_m_i, .addr_strobe_n_o, .cycle_op_o, .atomic_lock_n_o, .atomic_lock_oe_o,
      .split_cycle_flag_o, .yield_ack_o, .burst_ready_n_i, .backoff_n_i, .addr_freeze_req_i,
      .bus_yield_req_i, .snoop_addr_strobe_n_i);
   bus_responder bus_responder_i (.clk_i(clk_i), .strobe_n_i(addr_strobe_n_o), .op_i(cycle_op_o),
      .backoff_n_i(backoff_n_i), .delay_i(delay), .burst_ready_n_o(burst_ready_n_i));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [4:0] e(input op_e o, input logic l, input logic s);
      return {o, l, s};
   endfunction
   // cycle log and cache stand-in; a floated lock counts as released
   always @(posedge clk_i) begin
      lock_prev <= atomic_lock_n_o | ~atomic_lock_oe_o;
      snoop_hit_m_i <= snoop_look_o & hit_en;
      if (!addr_strobe_n_o) seen_q.push_back({cycle_op_o, atomic_lock_n_o, split_cycle_flag_o});
      if (line_inval_o) begin
         inval_n++;
         check({addr_strobe_n_o, atomic_lock_n_o, lock_prev}, 8'h01);
      end
      if (!atomic_lock_n_o && atomic_lock_oe_o) check(yield_ack_o, 8'h00);
      if (yield_ack_o) check(atomic_lock_oe_o, 8'h00);
   end
   // one request, then the strobed cycles against exp_q; inv ff skips the count
   task automatic run(input kind_e k, input logic m, input logic mis, input logic [7:0] inv);
      int n;
      n = 0;
      seen_q.delete();
      inval_n = 0;
      req_kind_i <= k;
      req_line_m_i <= m;
      req_misaligned_i <= mis;
      req_valid_i <= 1'b1;
      do @(posedge clk_i); while (!req_ready_o && ++n < 60);
      check(req_ready_o, 8'h01);
      req_valid_i <= 1'b0;
      n = 0;
      do @(posedge clk_i); while (!seq_done_o && ++n < 300);
      check(seq_done_o, 8'h01);
      check(8'(seen_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) check(seen_q[i], exp_q[i]);
      if (inv != 8'hff) check(8'(inval_n), inv);
   endtask
   task automatic t_modified;
      exp_q = '{e(OP_WB, 1, 0), e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      run(K_PROG, 1'b1, 1'b0, 8'h01);
      exp_q = '{e(OP_WB, 1, 0), e(OP_WB, 1, 0), e(OP_LRD, 0, 1), e(OP_LRD, 0, 1), e(OP_LWR, 0, 1),
         e(OP_LWR, 0, 1)};
      run(K_DESC, 1'b1, 1'b1, 8'h01);
   endtask
   task automatic t_clean;
      delay = 4'h0;
      exp_q = '{e(OP_LRD, 0, 1), e(OP_LRD, 0, 1), e(OP_LWR, 0, 1), e(OP_LWR, 0, 1)};
      run(K_XCHG, 1'b0, 1'b1, 8'h01);
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      run(K_PROG, 1'b0, 1'b0, 8'h01);
   endtask
   task automatic t_ignored;
      snoop_addr_strobe_n_i <= 1'b0;
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b1;
      repeat (6) begin
         @(posedge clk_i);
         check(snoop_look_o, 8'h00);
      end
   endtask
   task automatic t_table;
      delay = 4'h3;
      exp_q = '{e(OP_RD, 1, 0), e(OP_WB, 1, 0), e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      run(K_PT, 1'b1, 1'b1, 8'h01);
      pt_update_i <= 1'b0;
      exp_q = '{e(OP_RD, 1, 0)};
      run(K_PT, 1'b1, 1'b0, 8'h00);
      pt_update_i <= 1'b1;
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      run(K_PT, 1'b0, 1'b1, 8'h01);
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LRD, 0, 0)};
      run(K_INTA, 1'b0, 1'b1, 8'h00);
   endtask
   // backoff held across an optional inquire; lock must float meanwhile
   task automatic backoff_n_on(input op_e o, input logic hit);
      do @(posedge clk_i); while (addr_strobe_n_o || cycle_op_o != o);
      backoff_n_i <= 1'b0;
      hit_en = hit;
      repeat (2) @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b0;
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({atomic_lock_oe_o, addr_strobe_n_o}, 8'h01);
      repeat (4) @(posedge clk_i);
      backoff_n_i <= 1'b1;
   endtask
   task automatic t_backoff;
      delay = 4'h8;
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      fork run(K_PROG, 1'b0, 1'b0, 8'hff); backoff_n_on(OP_LRD, 1'b0); join
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LWR, 0, 0), e(OP_WB, 0, 0), e(OP_LWR, 0, 0)};
      fork run(K_PROG, 1'b0, 1'b0, 8'hff); backoff_n_on(OP_LWR, 1'b1); join
   endtask
   task automatic frz_on;
      do @(posedge clk_i); while (addr_strobe_n_o || cycle_op_o != OP_LRD);
      addr_freeze_req_i <= 1'b1;
      hit_en = 1'b1;
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b0;
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b1;
      repeat (6) begin
         @(posedge clk_i);
         check({atomic_lock_oe_o, atomic_lock_n_o}, 8'h02);
      end
      addr_freeze_req_i <= 1'b0;
   endtask
   task automatic t_freeze;
      delay = 4'hc;
      exp_q = '{e(OP_LRD, 0, 0), e(OP_WB, 0, 0), e(OP_LWR, 0, 0)};
      fork run(K_PROG, 1'b0, 1'b0, 8'h01); frz_on; join
   endtask
   task automatic t_yield;
      int n;
      n = 0;
      hit_en = 1'b0;
      delay = 4'h6;
      exp_q = '{e(OP_LRD, 0, 0), e(OP_LWR, 0, 0)};
      fork run(K_PROG, 1'b0, 1'b0, 8'h01); @(negedge addr_strobe_n_o) bus_yield_req_i <= 1'b1; join
      do @(posedge clk_i); while (!yield_ack_o && ++n < 20);
      check({yield_ack_o, atomic_lock_oe_o}, 8'h02);
      snoop_addr_strobe_n_i <= 1'b0;
      @(posedge clk_i);
      snoop_addr_strobe_n_i <= 1'b1;
      n = 0;
      do @(posedge clk_i); while (!snoop_look_o && ++n < 8);
      check(snoop_look_o, 8'h01);
      bus_yield_req_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({addr_strobe_n_o, atomic_lock_n_o, atomic_lock_oe_o, yield_ack_o}, 8'h0e);
      t_modified;
      t_clean;
      t_ignored;
      t_table;
      t_backoff;
      t_freeze;
      t_yield;
      close_out;
   end
   // cut a hang well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      close_out;
   end
endmodule // lock_seq_ctrl_tb
